// *** bench/octal_switch_fault_logic_sva.sv ***
// checker: port-level properties of the switch logic
`timescale 1ns/1ps
module octal_switch_fault_logic_sva (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // pins
    input wire logic chip_select_b,
    input wire logic serial_status_oe,
    input wire logic direct_drive_five,
    input wire logic direct_drive_six,
    input wire logic [7:0] over_temp,
    input wire logic load_power_supply_over,
    input wire logic logic_supply_under,
    input wire logic [7:0] output_on
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    property p_oe_on; $fell(chip_select_b) |-> ##[1:6] serial_status_oe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("driver not enabled");
    property p_oe_off; $rose(chip_select_b) |-> ##[1:6] !serial_status_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("driver not released");
    property p_ovr; load_power_supply_over[*5] |-> output_on == 8'h00; endproperty
    a_ovr: assert property (p_ovr) else $error("output on in overvoltage");
    property p_luv; logic_supply_under[*5] |-> output_on == 8'h00; endproperty
    a_luv: assert property (p_luv) else $error("output on in undervoltage");
    property p_five;
        (direct_drive_five && !over_temp[4] && !load_power_supply_over
            && !logic_supply_under)[*6] |-> output_on[4];
    endproperty
    a_five: assert property (p_five) else $error("pin five ignored");
    property p_six;
        (direct_drive_six && !over_temp[5] && !load_power_supply_over
            && !logic_supply_under)[*6] |-> output_on[5];
    endproperty
    a_six: assert property (p_six) else $error("pin six ignored");
    property p_hot; $stable(over_temp)[*5] |-> (over_temp & output_on) == 8'h00; endproperty
    a_hot: assert property (p_hot) else $error("hot output left on");
    // outputs move only on a select rise, a fault input or a direct-drive pin
    property p_hold;
        (!chip_select_b && $stable(over_temp) && $stable({direct_drive_five, direct_drive_six})
            && !load_power_supply_over && !logic_supply_under)[*6] |-> $stable(output_on);
    endproperty
    a_hold: assert property (p_hold) else $error("output moved mid frame");
endmodule : octal_switch_fault_logic_sva
bind octal_switch_fault_logic octal_switch_fault_logic_sva u_sva (.sys_clk(sys_clk),
    .rst_b(rst_b), .chip_select_b(chip_select_b), .serial_status_oe(serial_status_oe),
    .direct_drive_five(direct_drive_five), .direct_drive_six(direct_drive_six),
    .over_temp(over_temp), .load_power_supply_over(load_power_supply_over),
    .logic_supply_under(logic_supply_under), .output_on(output_on));

// *** bench/octal_switch_fault_logic_tb.sv ***
// testbench: transfers, thermal, open-load and supply events
`timescale 1ns/1ps
module octal_switch_fault_logic_tb;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cs_b, sclk, din, dout, oe, dd5 = 1'b0, dd6 = 1'b0;
    logic ovr = 1'b0, pun = 1'b0, lun = 1'b0;
    logic [7:0] ot = 8'h00, oc = 8'h00, ol = 8'h00, on;
    logic [15:0] rsp;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////
    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;
    spi_host u_host (.sys_clk(sys_clk), .cs_b(cs_b), .sclk(sclk), .din(din), .dout(dout));
    octal_switch_fault_logic #(.filter_count(20)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
        .chip_select_b(cs_b), .serial_clock(sclk), .serial_command_in(din),
        .serial_status_out(dout), .serial_status_oe(oe), .direct_drive_five(dd5),
        .direct_drive_six(dd6), .over_temp(ot), .over_current(oc), .open_load_cmp(ol),
        .load_power_supply_over(ovr), .load_power_supply_under(pun),
        .logic_supply_under(lun), .output_on(on));
    task automatic w(input int n);
        u_host.tick(n);
    endtask : w
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    // loopback word: status, then first byte back; second byte applied
    task automatic t_loop();
        u_host.xfer(16'ha53c, 1'b1, rsp);
        chk(rsp[15:8], 8'h00);
        chk(rsp[7:0], 8'ha5);
        chk(on, 8'h3c);
    endtask : t_loop
    // one hot output drops alone, reports, retries unless commanded off
    task automatic t_therm();
        u_host.xfer(16'h00ff, 1'b0, rsp);
        ot = 8'h04;
        oc = 8'h01;
        w(6);
        chk(on, 8'hfb);
        u_host.xfer(16'h00ff, 1'b0, rsp);
        // one sent, one back means short or hot
        chk(rsp[7:0], 8'h05);
        ot = 8'h00;
        oc = 8'h00;
        w(6);
        chk(on, 8'hff);
        ot = 8'h04;
        u_host.xfer(16'h00fb, 1'b0, rsp);
        ot = 8'h00;
        w(6);
        chk(on, 8'hfb);
    endtask : t_therm
    // open load: hidden inside the filter, latched after it
    task automatic t_open();
        u_host.xfer(16'h0080, 1'b0, rsp);
        ol = 8'hff;
        w(5);
        ol = 8'h00;
        u_host.xfer(16'h0080, 1'b0, rsp);
        chk(rsp[7:0], 8'h00);
        w(40);
        ol = 8'hff;
        w(5);
        ol = 8'h00;
        u_host.xfer(16'h0080, 1'b0, rsp);
        chk(rsp[7:0], 8'h7f);
    endtask : t_open
    // supplies and direct-drive pins
    task automatic t_supply();
        ovr = 1'b1;
        w(6);
        chk(on, 8'h00);
        ovr = 1'b0;
        w(6);
        chk(on, 8'h80);
        pun = 1'b1;
        u_host.xfer(16'h0081, 1'b0, rsp);
        chk(on, 8'h81);
        pun = 1'b0;
        dd5 = 1'b1;
        w(6);
        chk(on, 8'h91);
        dd5 = 1'b0;
        dd6 = 1'b1;
        w(6);
        chk(on, 8'ha1);
        dd6 = 1'b0;
        lun = 1'b1;
        ot = 8'h02;
        w(6);
        chk(on, 8'h00);
        u_host.xfer(16'h00ff, 1'b0, rsp);
        chk(rsp[7:0], 8'h00);
        lun = 1'b0;
        ot = 8'h00;
        w(6);
        u_host.xfer(16'h00ff, 1'b0, rsp);
        chk(on, 8'hff);
        // all off first, then logic power goes
        u_host.xfer(16'h0000, 1'b0, rsp);
        chk(on, 8'h00);
        lun = 1'b1;
        w(6);
        chk(on, 8'h00);
        lun = 1'b0;
    endtask : t_supply
    // hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_mismatch++;
            close_out();
        end
    end
    // main sequence
    initial begin
        w(10);
        rst_b = 1'b1;
        w(4);
        t_loop();
        t_therm();
        t_open();
        t_supply();
        close_out();
    end
endmodule : octal_switch_fault_logic_tb

// *** bench/spi_host.sv ***
// partner: serial host that shifts commands in and status out
`timescale 1ns/1ps
module spi_host (
    // clock
    input wire logic sys_clk,
    // serial link
    output logic cs_b,
    output logic sclk,
    output logic din,
    input wire logic dout
);
    // idle: deselected, clock low; data shows inverse of last bit
    initial begin
        cs_b = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    // spaced words, msb first, optional 16 bits
    task automatic xfer(input logic [15:0] cmd, input logic wide, output logic [15:0] rsp);
        int n;
        n = wide ? 16 : 8;
        rsp = 16'h0000;
        tick(30);
        cs_b = 1'b0;
        tick(8);
        for (int i = n - 1; i >= 0; i--) begin
            // data moves on the rise, held across the fall it is taken on
            din = cmd[i];
            sclk = 1'b1;
            tick(4);
            rsp = {rsp[14:0], dout};
            sclk = 1'b0;
            tick(4);
        end
        tick(4);
        cs_b = 1'b1;
        din = ~din;
        tick(6);
    endtask : xfer
endmodule : spi_host

// *** rtl/octal_switch_fault_logic.sv ***
// serial command, fault status and protection logic of an octal load switch
`timescale 1ns/1ps

// Contract
// - status word shifts out during command shift-in
// - status bit one means faulted output
// - last byte received is the command
// - per-output overtemperature shutdown, independent
// - overtemperature reports one, retries when cool
// - supply overvoltage turns all off, restores
// - open-load checked only while commanded off
// - chip select rise starts open-load filter
// - open-load fault latched until read
// - shorted output retries after cooling
// - logic undervoltage turns off, clears status
// - supply undervoltage does not affect outputs
// - cs rise applies command, fall loads status
// - sample on falling, shift on rising sclk
// - msb first, output eight first
// - outputs five and six ORed with pins
module octal_switch_fault_logic #(
    parameter int filter_count = switch_pkg::filter_cycles
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // serial link from the host
    input wire logic chip_select_b,
    input wire logic serial_clock,
    input wire logic serial_command_in,
    output logic serial_status_out,
    output logic serial_status_oe,
    // direct drive pins for outputs five and six
    input wire logic direct_drive_five,
    input wire logic direct_drive_six,
    // analog sensing, one bit per output
    input wire logic [7:0] over_temp,
    input wire logic [7:0] over_current,
    input wire logic [7:0] open_load_cmp,
    // global supply monitors
    input wire logic load_power_supply_over,
    input wire logic load_power_supply_under,
    input wire logic logic_supply_under,
    // gate drive
    output logic [7:0] output_on
);
    ////////////////////////////////////////////////////////////////////////
    // overview of the data path
    //
    // every pin, the serial link included, arrives asynchronously and is
    // passed through one shared two-flop synchroniser before anything reads
    // it. the serial clock is therefore only a level here: its edges are
    // found by comparing the synchronised level with its registered copy.
    //
    // the link is handled as an eight-bit shift register:
    //   - chip select falling loads the fault word and enables the driver
    //   - each serial clock rise presents the current msb on the pin
    //   - each serial clock fall shifts one command bit in at the lsb
    //   - chip select rising copies the register into the command
    //
    // because the register is only eight bits wide, a longer frame simply
    // pushes earlier bytes back out of the status pin; the last eight bits
    // received are what gets applied. this gives the loopback check for free.
    //
    // limitation: the serial clock must be slow against sys_clk. each half
    // period needs at least four sys_clk cycles, else edges are lost in the
    // synchroniser and the frame silently goes wrong.
    //
    // the protection path (thermal, supply) is purely combinational from
    // the synchronised levels into the drive register, so a shutdown takes
    // effect in a fixed three cycles whatever the link is doing.
    ////////////////////////////////////////////////////////////////////////
    // synchronise every pin input
    localparam int n_sync = 32;
    logic [n_sync-1:0] raw_in;
    logic [n_sync-1:0] sync_in;
    assign raw_in = {chip_select_b, serial_clock, serial_command_in,
                     direct_drive_five, direct_drive_six, over_temp,
                     over_current, open_load_cmp, load_power_supply_over,
                     load_power_supply_under, logic_supply_under};

    sync_bits #(.width(n_sync)) u_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .async_in(raw_in),
        .sync_out(sync_in)
    );

    logic s_cs_b;
    logic s_sclk;
    logic s_din;
    logic s_dd5;
    logic s_dd6;
    logic [7:0] s_ot;
    logic [7:0] s_oc;
    logic [7:0] s_ol;
    logic s_ov;
    logic s_uv_logic;
    assign s_cs_b = sync_in[31];
    assign s_sclk = sync_in[30];
    assign s_din = sync_in[29];
    assign s_dd5 = sync_in[28];
    assign s_dd6 = sync_in[27];
    assign s_ot = sync_in[26:19];
    assign s_oc = sync_in[18:11];
    assign s_ol = sync_in[10:3];
    assign s_ov = sync_in[2];
    // supply undervoltage, sync_in[1], is deliberately left without effect
    assign s_uv_logic = sync_in[0];

    ////////////////////////////////////////////////////////////////////////
    // state of the whole block
    typedef struct packed {
        logic cs_b_d;
        logic sclk_d;
        logic [7:0] shift;
        logic [7:0] command;
        logic [7:0] ol_latch;
        logic [switch_pkg::filter_cnt_width-1:0] filter_cnt;
        logic filter_done;
        logic dout;
        logic doe;
        logic [7:0] drive;
    } core_state_t;

    core_state_t state;
    core_state_t next_state;

    // fault sources combined per output
    function automatic logic [7:0] fault_of(input logic [7:0] ot, input logic [7:0] oc,
                                           input logic [7:0] ol);
        fault_of = ot | oc | ol;
    endfunction : fault_of

    // open-load event for one output: filter expired, commanded off, comparator set
    // used both by the running latch and by the reload at select fall, so the
    // two can never disagree on what counts as an open load
    function automatic logic ol_event(input logic done, input logic cmd_bit,
                                      input logic cmp);
        ol_event = done & ~cmd_bit & cmp;
    endfunction : ol_event

    // edge detection on synchronised levels
    // the registered copies reset to the idle levels of their pins (select
    // high, clock low), but the synchroniser resets to zero, so select reads
    // low just after reset and a false select fall and then rise follow reset

    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic [7:0] cmd_eff;
    assign cs_fall = state.cs_b_d & ~s_cs_b;
    assign cs_rise = ~state.cs_b_d & s_cs_b;
    assign sclk_rise = ~state.sclk_d & s_sclk;
    assign sclk_fall = state.sclk_d & ~s_sclk;

    // effective command with direct drive
    always_comb begin
        cmd_eff = state.command;
        cmd_eff[switch_pkg::drive_five_bit] = state.command[switch_pkg::drive_five_bit] | s_dd5;
        cmd_eff[switch_pkg::drive_six_bit] = state.command[switch_pkg::drive_six_bit] | s_dd6;
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_state = state;
        next_state.cs_b_d = s_cs_b;
        next_state.sclk_d = s_sclk;

        // filter timer restarts on every cs rise
        // filter timer start
        if (cs_rise) begin
            next_state.filter_cnt = '0;
            next_state.filter_done = 1'b0;
        end else if (!state.filter_done) begin
            if (state.filter_cnt ==
                switch_pkg::filter_cnt_width'(filter_count - 1)) begin
                next_state.filter_done = 1'b1;
            end else begin
                next_state.filter_cnt = state.filter_cnt + 1'b1;
            end
        end

        // latch until loaded
        // an on output is never checked: its drain sits near the rail anyway
        for (int i = 0; i < 8; i++) begin
            if (ol_event(state.filter_done, cmd_eff[i], s_ol[i])) begin
                next_state.ol_latch[i] = 1'b1;
            end
        end

        // serial shifting while selected
        if (!s_cs_b) begin
            if (sclk_fall) begin
                next_state.shift = {state.shift[6:0], s_din};
            end
            if (sclk_rise) begin
                next_state.dout = state.shift[7];
            end
        end

        if (cs_fall) begin
            next_state.shift = fault_of(s_ot, s_oc, state.ol_latch);
            // a fault arriving now stays latched for next read
            // clearing and setting in one cycle: the set wins
            for (int i = 0; i < 8; i++) begin
                next_state.ol_latch[i] = ol_event(state.filter_done, cmd_eff[i], s_ol[i]);
            end
            next_state.doe = 1'b1;
            next_state.dout = 1'b0;
        end

        if (cs_rise) begin
            next_state.command = state.shift;
            next_state.doe = 1'b0;
        end

        // supply undervoltage ignored
        // the command itself is untouched by thermal or overvoltage events,
        // so each output returns to its commanded level once the cause clears;
        // overcurrent is left to the analog limit and does not gate the drive
        next_state.drive = cmd_eff & ~s_ot & {8{~s_ov}};

        // logic undervoltage off and cleared
        // placed last so it overrides the drive, command, latch, shift and dout updates of the same cycle;
        // the stored command is cleared too, so outputs stay off after
        // recovery until the host writes a new word, save five and six while their pins are high
        if (s_uv_logic) begin
            next_state.drive = '0;
            next_state.command = switch_pkg::command_reset;
            next_state.ol_latch = switch_pkg::status_reset;
            next_state.shift = switch_pkg::status_reset;
            next_state.dout = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register the state
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '{cs_b_d: 1'b1, sclk_d: 1'b0,
                       shift: switch_pkg::status_reset,
                       command: switch_pkg::command_reset,
                       ol_latch: switch_pkg::status_reset,
                       filter_cnt: '0, filter_done: 1'b0,
                       dout: 1'b0, doe: 1'b0, drive: '0};
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    // the status pin keeps its last value while the enable is low, unless logic undervoltage clears it; the pad
    // is expected to float it, so a reader must qualify it with the enable
    assign serial_status_out = state.dout;
    assign serial_status_oe = state.doe;
    assign output_on = state.drive;
endmodule : octal_switch_fault_logic

// *** rtl/switch_pkg.sv ***
// package: constants for the octal switch fault logic
package switch_pkg;
    localparam int num_outputs = 8;
    // open-load filter window after chip select rises, in microseconds
    localparam int filter_min_us = 100;
    localparam int filter_max_us = 300;
    localparam int clk_mhz = 100;
    // least time rounds up; figure in whole microseconds so exact
    localparam int filter_cycles = filter_min_us * clk_mhz;
    localparam int filter_cnt_width = 16;
    localparam logic [7:0] command_reset = 8'h00;
    localparam logic [7:0] status_reset = 8'h00;
    // bit positions of the two direct-drive outputs (five and six)
    localparam int drive_five_bit = 4;
    localparam int drive_six_bit = 5;
endpackage : switch_pkg

// *** rtl/sync_bits.sv ***
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module sync_bits #(
    parameter int width = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // levels in and out
    input wire logic [width-1:0] async_in,
    output logic [width-1:0] sync_out
);
    typedef struct packed {
        logic [width-1:0] meta;
        logic [width-1:0] stable;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    // first stage is read only by the second
    always_comb begin
        next_state = state;
        next_state.meta = async_in;
        next_state.stable = state.meta;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.stable;
endmodule : sync_bits
